// file: design/cell_mon_pkg.sv
// Constants, register map and state codes of the cell monitor register bank.
// Assumes a 50 MHz system clock and an I2C master on the pins.
package cell_mon_pkg;

   localparam int REG_COUNT = 10;

   localparam logic [7:0] ADDR_SLEEP_REF_PUMP_MONITOR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BALANCE_SWITCH_CTRL = 8'h01;
   localparam logic [7:0] ADDR_CURRENT_MONITOR_SETTING = 8'h02;
   localparam logic [7:0] ADDR_SHORT_CURRENT_SETTING_ONE = 8'h03;
   localparam logic [7:0] ADDR_SHORT_CURRENT_SETTING_TWO = 8'h04;
   localparam logic [7:0] ADDR_SHORT_CURRENT_CONTROL = 8'h05;
   localparam logic [7:0] ADDR_OVER_TEMP_THERMAL_SETTING = 8'h06;
   localparam logic [7:0] ADDR_CHIP_STATE = 8'h07;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h09;
   localparam logic [7:0] REG_LIMIT = 8'h0a;

   typedef logic [REG_COUNT-1:0][7:0] reg_array_type;

   // Power-on values, highest address first
   localparam reg_array_type REG_RESET = {
      8'h00, 8'h00, 8'h00, 8'h92, 8'h03, 8'h01, 8'h81, 8'h00, 8'h00, 8'h80
   };

   localparam int SLEEP_HI_POS = 7;
   localparam int SLEEP_LO_POS = 6;
   localparam int REF_EN_POS = 5;
   localparam int MON_EN_POS = 4;
   localparam int PUMP_ON_POS = 3;
   localparam int CELL_SEL_MSB_POS = 2;
   localparam int CELL_SEL_LSB_POS = 0;
   localparam logic [1:0] SLEEP_ENTER_CODE = 2'h1;
   localparam logic SLEEP_RESET = 1'b0;

   localparam logic [6:0] SLAVE_ADDR = 7'h5d;
   localparam logic [2:0] LAST_BIT = 3'h7;

   localparam int CLK_HZ = 50_000_000;
   localparam int T_OUT_MS = 32;
   localparam int T_OUT_CYCLES = T_OUT_MS * (CLK_HZ / 1000);
   localparam int TOUT_W = 21;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_ADDR = 4'h1,
      ST_REG = 4'h2,
      ST_WDATA = 4'h3,
      ST_ACK_PEND = 4'h4,
      ST_ACK = 4'h5,
      ST_TX = 4'h6,
      ST_MACK = 4'h7,
      ST_TX_LOAD = 4'h8
   } i2c_state_type;

endpackage : cell_mon_pkg

// file: design/cell_mon_ifs.sv
// Carriers between the link engine, the pin sampler and the register bank.
// Assumes all three sit on clock_i.
`timescale 1ns/1ps

interface reg_access_if;
   logic wr_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport master (output wr_stb, output addr, output wdata, input rdata);
   modport slave (input wr_stb, input addr, input wdata, output rdata);
endinterface : reg_access_if

interface line_event_if;
   logic sda_level;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   modport src (output sda_level, output scl_rise, output scl_fall,
      output start_seen, output stop_seen);
   modport dst (input sda_level, input scl_rise, input scl_fall,
      input start_seen, input stop_seen);
endinterface : line_event_if

// file: design/i2c_pin_sampler.sv
// Two-stage synchronisers on the bus pins and line event detection.
// Assumes SCL and SDA arrive asynchronously and idle high.
`timescale 1ns/1ps

module i2c_pin_sampler
   import cell_mon_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   line_event_if.src ev
);

   typedef struct packed {
      logic scl_meta;
      logic scl_sync;
      logic scl_prev;
      logic sda_meta;
      logic sda_sync;
      logic sda_prev;
   } sampler_state_type;

   sampler_state_type cur_ff;
   sampler_state_type nxt_ff;

   always_comb begin
      nxt_ff.scl_meta = scl_i;
      nxt_ff.scl_sync = cur_ff.scl_meta;
      nxt_ff.scl_prev = cur_ff.scl_sync;
      nxt_ff.sda_meta = sda_i;
      nxt_ff.sda_sync = cur_ff.sda_meta;
      nxt_ff.sda_prev = cur_ff.sda_sync;
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cur_ff <= '1;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // Start and stop are SDA edges while SCL stays high
   assign ev.sda_level = cur_ff.sda_sync;
   assign ev.scl_rise = cur_ff.scl_sync & ~cur_ff.scl_prev;
   assign ev.scl_fall = ~cur_ff.scl_sync & cur_ff.scl_prev;
   assign ev.start_seen = cur_ff.scl_sync & cur_ff.scl_prev &
      cur_ff.sda_prev & ~cur_ff.sda_sync; // [R10]
   assign ev.stop_seen = cur_ff.scl_sync & cur_ff.scl_prev &
      ~cur_ff.sda_prev & cur_ff.sda_sync; // [R10]

endmodule : i2c_pin_sampler

// file: design/cell_regs_bank.sv
// Ten 8-bit control and status registers of the cell monitor.
// Assumes status inputs are driven by logic on clock_i.
`timescale 1ns/1ps

module cell_regs_bank
   import cell_mon_pkg::*;
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   reg_access_if.slave acc,
   input wire logic [7:0] chip_state_i,
   input wire logic [7:0] irq_flags_i,
   output logic [REG_COUNT-1:0][7:0] reg_val_o,
   output logic sleep_enter_o
);

   typedef struct packed {
      reg_array_type regs;
      logic sleep;
   } bank_state_type;

   bank_state_type cur_ff;
   bank_state_type nxt_ff;

   always_comb begin
      nxt_ff = cur_ff;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (acc.wr_stb && acc.addr == 8'(i)) begin
            nxt_ff.regs[i] = acc.wdata; // [R1] [R12]
         end
      end
      // Read-only registers follow their sources, writes are lost
      nxt_ff.regs[ADDR_CHIP_STATE[3:0]] = chip_state_i; // [R1] [R12]
      nxt_ff.regs[ADDR_IRQ_FLAGS[3:0]] = irq_flags_i; // [R1] [R12]
      nxt_ff.sleep = {nxt_ff.regs[0][SLEEP_HI_POS],
         nxt_ff.regs[0][SLEEP_LO_POS]} == SLEEP_ENTER_CODE; // [R3]
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cur_ff.regs <= REG_RESET; // [R2]
         cur_ff.sleep <= SLEEP_RESET; // [R3]
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // Unmapped addresses read as zero
   always_comb begin
      acc.rdata = 8'h00;
      if (acc.addr < REG_LIMIT) begin
         acc.rdata = cur_ff.regs[acc.addr[3:0]]; // [R1]
      end
   end

   assign reg_val_o = cur_ff.regs;
   assign sleep_enter_o = cur_ff.sleep;

endmodule : cell_regs_bank

// file: design/cell_monitor_ctrl_regs.sv
// I2C slave register interface and control decode of the cell monitor.
// Assumes an I2C master on SCL/SDA with external pull-ups, SCL low and
// high phases of at least eight clock_i cycles each.
`timescale 1ns/1ps

// What this block does
// R1: Ten 8-bit registers, two read-only.
// R2: Power-on values per register loaded.
// R3: Only sleep code 01 enters sleep.
// R4: Bit 5 enables reference output.
// R5: Bit 4 enables cell voltage monitor.
// R6: Bit 3 enables charge pump.
// R7: Bits 2..0 select monitored cell.
// R8: Register 01H bits close balance switches.
// R9: Master clears balancing before measuring; this block does not enforce it.
// R10: Write: address, register byte, data bytes.
// R11: Read: set pointer, then read bytes.
// R12: Read-only writes ignored; pointer auto-increments.
module cell_monitor_ctrl_regs
   import cell_mon_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = T_OUT_CYCLES
)
(
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   input wire logic [7:0] chip_state_i,
   input wire logic [7:0] irq_flags_i,
   output logic sleep_enter_o,
   output logic ref_out_en_o,
   output logic monitor_en_o,
   output logic pump_on_o,
   output logic [2:0] cell_sel_o,
   output logic [7:0] balance_en_o,
   output logic [7:0] current_monitor_setting_o,
   output logic [7:0] short_current_setting_one_o,
   output logic [7:0] short_current_setting_two_o,
   output logic [7:0] short_current_control_o,
   output logic [7:0] over_temp_thermal_setting_o,
   output logic [7:0] irq_mask_o
);

   typedef struct packed {
      i2c_state_type st;
      i2c_state_type after;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      logic [7:0] ptr;
      logic sda_low;
      logic wr_stb;
      logic [7:0] wr_addr;
      logic [7:0] wdata;
      logic [TOUT_W-1:0] tcount;
   } link_state_type;

   localparam logic [TOUT_W-1:0] TOUT_LAST = TOUT_W'(TIMEOUT_CYCLES - 1);

   link_state_type cur_ff;
   link_state_type nxt_ff;
   logic [7:0] rx_byte;
   logic [REG_COUNT-1:0][7:0] reg_val;

   reg_access_if acc ();
   line_event_if ev ();

   i2c_pin_sampler u_sampler (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ev(ev)
   );

   cell_regs_bank u_bank (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .acc(acc),
      .chip_state_i(chip_state_i),
      .irq_flags_i(irq_flags_i),
      .reg_val_o(reg_val),
      .sleep_enter_o(sleep_enter_o)
   );

   assign rx_byte = {cur_ff.shreg[6:0], ev.sda_level};

   always_comb begin
      nxt_ff = cur_ff;
      nxt_ff.wr_stb = 1'b0;
      if (cur_ff.st != ST_IDLE) begin
         nxt_ff.tcount = cur_ff.tcount + 1'b1;
      end
      // Bus time-out restarts on every SCL falling edge
      if (ev.scl_fall) begin
         nxt_ff.tcount = '0;
      end
      if (ev.start_seen) begin
         nxt_ff.st = ST_ADDR; // [R10] [R11]
         nxt_ff.bitcnt = '0;
         nxt_ff.sda_low = 1'b0;
         nxt_ff.tcount = '0;
      end else if (ev.stop_seen ||
            (cur_ff.st != ST_IDLE && cur_ff.tcount == TOUT_LAST)) begin
         nxt_ff.st = ST_IDLE;
         nxt_ff.sda_low = 1'b0;
         nxt_ff.tcount = '0;
      end else begin
         unique case (cur_ff.st)
            ST_IDLE: begin
               nxt_ff.sda_low = 1'b0;
            end
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (ev.scl_rise) begin
                  nxt_ff.shreg = rx_byte;
                  nxt_ff.bitcnt = cur_ff.bitcnt + 1'b1;
                  if (cur_ff.bitcnt == LAST_BIT) begin
                     nxt_ff.st = ST_ACK_PEND;
                     nxt_ff.after = ST_WDATA;
                     if (cur_ff.st == ST_ADDR) begin
                        if (rx_byte[7:1] != SLAVE_ADDR) begin
                           nxt_ff.st = ST_IDLE;
                        end else if (rx_byte[0]) begin
                           nxt_ff.after = ST_TX; // [R11]
                        end else begin
                           nxt_ff.after = ST_REG; // [R10]
                        end
                     end else if (cur_ff.st == ST_REG) begin
                        nxt_ff.ptr = rx_byte; // [R10] [R11]
                     end else begin
                        nxt_ff.wr_stb = 1'b1; // [R10]
                        nxt_ff.wr_addr = cur_ff.ptr;
                        nxt_ff.wdata = rx_byte;
                        nxt_ff.ptr = cur_ff.ptr + 1'b1; // [R12]
                     end
                  end
               end
            end
            ST_ACK_PEND: begin
               if (ev.scl_fall) begin
                  nxt_ff.sda_low = 1'b1;
                  nxt_ff.st = ST_ACK;
               end
            end
            ST_ACK: begin
               if (ev.scl_fall) begin
                  nxt_ff.bitcnt = '0;
                  if (cur_ff.after == ST_TX) begin
                     nxt_ff.shreg = acc.rdata; // [R11]
                     nxt_ff.sda_low = ~acc.rdata[7];
                     nxt_ff.st = ST_TX;
                  end else begin
                     nxt_ff.sda_low = 1'b0;
                     nxt_ff.st = cur_ff.after;
                  end
               end
            end
            ST_TX: begin
               if (ev.scl_fall) begin
                  if (cur_ff.bitcnt == LAST_BIT) begin
                     nxt_ff.sda_low = 1'b0;
                     nxt_ff.st = ST_MACK;
                  end else begin
                     nxt_ff.bitcnt = cur_ff.bitcnt + 1'b1;
                     nxt_ff.shreg = {cur_ff.shreg[6:0], 1'b0};
                     nxt_ff.sda_low = ~cur_ff.shreg[6]; // [R11]
                  end
               end
            end
            ST_MACK: begin
               if (ev.scl_rise) begin
                  nxt_ff.ptr = cur_ff.ptr + 1'b1; // [R12]
                  nxt_ff.st = ev.sda_level ? ST_IDLE : ST_TX_LOAD;
               end
            end
            ST_TX_LOAD: begin
               if (ev.scl_fall) begin
                  nxt_ff.shreg = acc.rdata; // [R11]
                  nxt_ff.sda_low = ~acc.rdata[7];
                  nxt_ff.bitcnt = '0;
                  nxt_ff.st = ST_TX;
               end
            end
            default: begin
               nxt_ff.st = ST_IDLE;
               nxt_ff.sda_low = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cur_ff.st <= ST_IDLE;
         cur_ff.after <= ST_IDLE;
         cur_ff.shreg <= '0;
         cur_ff.bitcnt <= '0;
         cur_ff.ptr <= '0;
         cur_ff.sda_low <= 1'b0;
         cur_ff.wr_stb <= 1'b0;
         cur_ff.wr_addr <= '0;
         cur_ff.wdata <= '0;
         cur_ff.tcount <= '0;
      end else begin
         cur_ff <= nxt_ff;
      end
   end

   // Write address is shown only during the one-cycle strobe
   assign acc.wr_stb = cur_ff.wr_stb;
   assign acc.addr = cur_ff.wr_stb ? cur_ff.wr_addr : cur_ff.ptr;
   assign acc.wdata = cur_ff.wdata;

   // Open-drain data line: only ever pulled low
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~cur_ff.sda_low;

   // Analog control decode
   assign ref_out_en_o = reg_val[0][REF_EN_POS]; // [R4]
   assign monitor_en_o = reg_val[0][MON_EN_POS]; // [R5]
   assign pump_on_o = reg_val[0][PUMP_ON_POS]; // [R6]
   assign cell_sel_o = reg_val[0][CELL_SEL_MSB_POS:CELL_SEL_LSB_POS]; // [R7]
   assign balance_en_o = reg_val[ADDR_BALANCE_SWITCH_CTRL[3:0]]; // [R8]
   assign current_monitor_setting_o =
      reg_val[ADDR_CURRENT_MONITOR_SETTING[3:0]];
   assign short_current_setting_one_o =
      reg_val[ADDR_SHORT_CURRENT_SETTING_ONE[3:0]];
   assign short_current_setting_two_o =
      reg_val[ADDR_SHORT_CURRENT_SETTING_TWO[3:0]];
   assign short_current_control_o = reg_val[ADDR_SHORT_CURRENT_CONTROL[3:0]];
   assign over_temp_thermal_setting_o =
      reg_val[ADDR_OVER_TEMP_THERMAL_SETTING[3:0]];
   assign irq_mask_o = reg_val[ADDR_IRQ_MASK[3:0]];

endmodule : cell_monitor_ctrl_regs

// file: verification/cell_monitor_ctrl_regs_assertions.sv
// Port-level checker for the cell monitor register bank.
// Assumes the bus pins idle high and SCL phases last eight clocks or more.
`timescale 1ns/1ps

module cell_monitor_ctrl_regs_checker (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic sleep_enter_o,
   input wire logic ref_out_en_o,
   input wire logic monitor_en_o,
   input wire logic pump_on_o,
   input wire logic [2:0] cell_sel_o,
   input wire logic [7:0] balance_en_o,
   input wire logic [7:0] current_monitor_setting_o,
   input wire logic [7:0] short_current_setting_one_o,
   input wire logic [7:0] irq_mask_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   a_reset_values: assert property ($fell(sys_rst_i) |-> sda_oe_n_o &&
      !sleep_enter_o && balance_en_o == 8'h00 && cell_sel_o == 3'h0 &&
      short_current_setting_one_o == 8'h81 && irq_mask_o == 8'h00)
      else $error("outputs not at power-on values");
   a_sda_drive_zero: assert property (!sda_oe_n_o |-> sda_o == 1'b0)
      else $error("driven data level not low");
   a_sda_change_low: assert property ($changed(sda_oe_n_o) |->
      !scl_i && !$past(scl_i) && !$past(scl_i, 2))
      else $error("data line changed while clock high");
   a_drive_bounded: assert property (!sda_oe_n_o |-> ##[1:400] sda_oe_n_o)
      else $error("data line held too long");
   a_stop_release: assert property (scl_i && $rose(sda_i) |=>
      sda_oe_n_o [*8])
      else $error("data line driven after stop");
   a_ctrl_write_high: assert property ($changed({sleep_enter_o,
      ref_out_en_o, monitor_en_o, pump_on_o, cell_sel_o}) |->
      scl_i && !$past(scl_i, 8))
      else $error("control outputs changed outside a data bit");
   a_balance_stable_low: assert property (!scl_i && !$past(scl_i) |->
      $stable(balance_en_o))
      else $error("balance outputs changed with clock low");
   a_setting_write_high: assert property ($changed({irq_mask_o,
      current_monitor_setting_o, short_current_setting_one_o}) |->
      scl_i && $past(scl_i, 2))
      else $error("setting outputs changed outside a data bit");
endmodule : cell_monitor_ctrl_regs_checker

bind cell_monitor_ctrl_regs cell_monitor_ctrl_regs_checker chk_u (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .sleep_enter_o(sleep_enter_o),
   .ref_out_en_o(ref_out_en_o), .monitor_en_o(monitor_en_o),
   .pump_on_o(pump_on_o), .cell_sel_o(cell_sel_o),
   .balance_en_o(balance_en_o),
   .current_monitor_setting_o(current_monitor_setting_o),
   .short_current_setting_one_o(short_current_setting_one_o),
   .irq_mask_o(irq_mask_o));

// file: verification/cell_mon_master_model.sv
// Behavioural bus master driving SCL and an open-drain SDA.
// Assumes the bench resolves the SDA wire with the device's enable.
`timescale 1ns/1ps

module cell_mon_master_model (
   input wire logic clock_i,
   input wire logic sda_bus_i,
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : wait_clk

   // Start or repeated start
   task automatic start_cond;
      sda_o = 1'b1;
      wait_clk(5);
      scl_o = 1'b1;
      wait_clk(10);
      sda_o = 1'b0;
      wait_clk(10);
      scl_o = 1'b0;
      wait_clk(5);
   endtask : start_cond

   task automatic stop_cond;
      sda_o = 1'b0;
      wait_clk(5);
      scl_o = 1'b1;
      wait_clk(10);
      sda_o = 1'b1;
      wait_clk(10);
   endtask : stop_cond

   // Eight bits MSB first, then the acknowledge bit
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
      input logic last, output logic ack);
      for (int i = 8; i >= 0; i--) begin
         sda_o = (i == 0) ? last : tx[i-1];
         wait_clk(5);
         scl_o = 1'b1;
         wait_clk(5);
         if (i == 0) begin
            ack = sda_bus_i;
         end else begin
            rx[i-1] = sda_bus_i;
         end
         wait_clk(5);
         scl_o = 1'b0;
         wait_clk(5);
      end
   endtask : byte_io
endmodule : cell_mon_master_model

// file: verification/cell_monitor_ctrl_regs_tb.sv
// Self-checking bench for the cell monitor register bank.
// Assumes the master model and the checker are compiled alongside.
`timescale 1ns/1ps

module cell_monitor_ctrl_regs_tb;
   import cell_mon_pkg::*;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic scl, sda_m, sda_bus, sda_o, sda_oe_n, ack, sleep_o, ref_o, mon_o;
   logic pump_o;
   logic [2:0] sel_o;
   logic [7:0] chip_state = 8'h00;
   logic [7:0] irq_flags = 8'h00;
   logic [7:0] bal_o, cms_o, sc1_o, sc2_o, scc_o, ots_o, msk_o, r, d, b;
   logic [7:0] q[$];
   logic [7:0] por[10] = '{8'h80, 8'h00, 8'h00, 8'h81, 8'h01, 8'h03, 8'h92,
      8'h00, 8'h00, 8'h00};
   int errors = 0;
   int check_count = 0;
   int cyc = 0;

   always #10 clock_i = ~clock_i;
   assign sda_bus = sda_m & (sda_oe_n | sda_o);

   cell_monitor_ctrl_regs #(.TIMEOUT_CYCLES(200)) dut_u (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o),
      .sda_oe_n_o(sda_oe_n), .chip_state_i(chip_state),
      .irq_flags_i(irq_flags), .sleep_enter_o(sleep_o), .ref_out_en_o(ref_o),
      .monitor_en_o(mon_o), .pump_on_o(pump_o), .cell_sel_o(sel_o),
      .balance_en_o(bal_o), .current_monitor_setting_o(cms_o),
      .short_current_setting_one_o(sc1_o),
      .short_current_setting_two_o(sc2_o), .short_current_control_o(scc_o),
      .over_temp_thermal_setting_o(ots_o), .irq_mask_o(msk_o));

   cell_mon_master_model mst_u (.clock_i(clock_i), .sda_bus_i(sda_bus),
      .scl_o(scl), .sda_o(sda_m));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize;
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   task automatic send(input logic [7:0] v);
      mst_u.byte_io(v, r, 1'b1, ack);
      check(ack, 1'b0);
   endtask : send

   task automatic wr(input logic [7:0] a, input logic [7:0] dq[$]);
      mst_u.start_cond();
      send({SLAVE_ADDR, 1'b0});
      send(a);
      foreach (dq[i]) send(dq[i]);
      mst_u.stop_cond();
   endtask : wr

   task automatic rd(input logic [7:0] a, input int n);
      mst_u.start_cond();
      send({SLAVE_ADDR, 1'b0});
      send(a);
      mst_u.start_cond();
      send({SLAVE_ADDR, 1'b1});
      q = {};
      for (int i = 0; i < n; i++) begin
         mst_u.byte_io(8'hff, r, i == n - 1, ack);
         q.push_back(r);
      end
      mst_u.stop_cond();
   endtask : rd

   task automatic chk_ctrl(input logic [7:0] dv, input logic [7:0] bv);
      check(sleep_o, dv[7:6] == 2'b01);
      check(ref_o, dv[5]);
      check(mon_o, dv[4]);
      check(pump_o, dv[3]);
      check(sel_o, dv[2:0]);
      check(bal_o, bv);
   endtask : chk_ctrl

   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         summarize();
      end
   end

   initial begin
      repeat (10) @(posedge clock_i);
      #1 sys_rst_i = 1'b0;
      mst_u.wait_clk(3);
      chk_ctrl(8'h80, 8'h00);
      check({cms_o, sc1_o, sc2_o, scc_o, ots_o, msk_o}, 48'h0081_0103_9200);
      rd(8'h00, 10);
      foreach (q[i]) check(q[i], por[i]);
      for (int i = 0; i < 8; i++) begin
         d = {i[1:0], i[2], i[0], ~i[1], i[2:0]};
         b = d[4] ? 8'h00 : ~(8'h01 << i);
         wr(8'h01, '{8'h00});
         wr(8'h00, '{d, b});
         chk_ctrl(d, b);
         rd(8'h00, 2);
         check({q[0], q[1]}, {d, b});
      end
      chip_state = 8'ha5;
      irq_flags = 8'h3c;
      wr(8'h02, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88,
         8'h99});
      check({cms_o, sc1_o, sc2_o, scc_o, ots_o, msk_o}, 48'h1122_3344_5577);
      rd(8'h06, 5);
      check({q[0], q[1], q[2], q[3], q[4]}, 40'h55a5_773c_00);
      mst_u.start_cond();
      mst_u.byte_io(8'hb8, r, 1'b1, ack);
      check(ack, 1'b1);
      mst_u.byte_io(8'h00, r, 1'b1, ack);
      check(ack, 1'b1);
      mst_u.byte_io(8'h40, r, 1'b1, ack);
      check(ack, 1'b1);
      mst_u.stop_cond();
      // Stalled read: device drives bit 7 low, then the time-out frees SDA
      mst_u.start_cond();
      send({SLAVE_ADDR, 1'b1});
      check(sda_oe_n, 1'b0);
      mst_u.wait_clk(300);
      check(sda_oe_n, 1'b1);
      mst_u.byte_io(8'h00, r, 1'b1, ack);
      check(ack, 1'b1);
      mst_u.stop_cond();
      chk_ctrl(d, b);
      summarize();
   end
endmodule : cell_monitor_ctrl_regs_tb
